/* hdl/pxe_pkg.sv */
package pxe_pkg;
  // fixed upper address prefix, a6..a4
  localparam logic [2:0] ADDR_PREFIX   = 3'h5;
  // connection codes of an address-select input
  localparam logic [1:0] SEL_GND       = 2'h0;
  localparam logic [1:0] SEL_VDD       = 2'h1;
  localparam logic [1:0] SEL_SDA       = 2'h2;
  localparam logic [1:0] SEL_SCL       = 2'h3;
  // default two-bit address code per connection, gnd/vdd/sda/scl order
  localparam logic [7:0] SEL_MAP_LOW   = 8'he4;
  localparam logic [7:0] SEL_MAP_HIGH  = 8'he4;
  // bus speed: clk cycles per scl quarter period
  localparam int         SCL_QUARTER_NS = 2500;
  localparam int         CLK_PERIOD_NS  = 40;
  localparam logic [7:0] QUARTER_CYC   =
    8'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] OUT_RESET     = 8'h00;

  typedef enum logic [2:0] {
    PXE_IDLE = 3'b000,
    PXE_ADDR = 3'b001,
    PXE_AACK = 3'b011,
    PXE_DATA = 3'b010,
    PXE_DACK = 3'b110,
    PXE_SKIP = 3'b111
  } pxe_dev_e;

  // map one select connection to its two address bits
  function automatic logic [1:0] sel_code(input logic [7:0] map,
                                          input logic [1:0] conn);
    sel_code = map[conn*2 +: 2];
  endfunction : sel_code
endpackage : pxe_pkg

/* hdl/pxe_if.sv */
interface pxe_if;
  logic scl_out;
  logic scl_oe_b;
  logic sda_host_out;
  logic sda_host_oe_b;
  logic sda_dev_out;
  logic sda_dev_oe_b;
  logic scl;
  logic sda;

  // open-drain wired-and with pullups
  assign scl = scl_oe_b | scl_out;
  assign sda = (sda_host_oe_b | sda_host_out) & (sda_dev_oe_b | sda_dev_out);

  modport host (output scl_out, output scl_oe_b, output sda_host_out,
                output sda_host_oe_b, input scl, input sda);
  modport dev  (output sda_dev_out, output sda_dev_oe_b,
                input scl, input sda);
endinterface : pxe_if

/* hdl/pxe_dev.sv */
// Contract
// - start is sda fall while scl high
// - stop is sda rise while scl high
// - one bit per pulse, stable high
// - master sends start address data stop
// - receiver acks low on ninth pulse
// - eighth bit: zero write, one read
// - match only prefix one zero one
// - select inputs give low four bits
// - read captures pins at address ack
// - read data comes from sensed pins
// - each read ack recaptures pins
// - master acks reads, ends with stop
// - each write byte acked, loads outputs
// - write address ack also samples pins; the code samples pins only on reads
// - never drive scl, sda only low
// - idle bus lines stay released high
// - master alone starts and clocks transfers
// - reset aborts transfer, keeps outputs
// - power-up outputs follow select inputs
// - address redecoded every transmission
module pxe_dev #(
  parameter logic [7:0] MAP_LOW  = pxe_pkg::SEL_MAP_LOW,
  parameter logic [7:0] MAP_HIGH = pxe_pkg::SEL_MAP_HIGH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bus
  pxe_if.dev              bus,
  // address select connections, codes from the package
  input  wire logic [1:0] addr_select_in_low,
  input  wire logic [1:0] addr_select_in_high,
  // ports: driven levels and sensed pin levels
  output logic      [7:0] push_pull_outputs,
  input  wire logic [7:0] pin_levels
);
  typedef struct packed {
    logic [1:0]       scl_s;
    logic [1:0]       sda_s;
    logic             scl_q;
    logic             sda_q;
    logic [7:0]       pin_s0;
    logic [7:0]       pin_s1;
    logic [1:0]       sl_s0;
    logic [1:0]       sh_s0;
    logic [1:0]       sl_s1;
    logic [1:0]       sh_s1;
    logic [3:0]       addr_lo;
    logic [1:0]       boot;
    pxe_pkg::pxe_dev_e st;
    logic [3:0]       cnt;
    logic [7:0]       shreg;
    logic             rd;
    logic             ack_ok;
    logic             sda_low;
    logic [7:0]       outs;
  } pxe_dev_s;

  // power-up value only: boot counts from zero, outputs start low;
  // the sync reset never clears boot or outs, so a reset keeps the ports
  pxe_dev_s cur = '0;
  pxe_dev_s next_cur;
  logic     scl_rise;
  logic     scl_fall;
  logic     start_c;
  logic     stop_c;

  // edges compare the second synchroniser stage with its delayed copy
  assign scl_rise = cur.scl_s[1] & ~cur.scl_q;
  assign scl_fall = ~cur.scl_s[1] & cur.scl_q;
  assign start_c  = cur.scl_s[1] & cur.scl_q &
                    cur.sda_q & ~cur.sda_s[1];
  assign stop_c   = cur.scl_s[1] & cur.scl_q &
                    ~cur.sda_q & cur.sda_s[1];

  // whole protocol engine
  always_comb begin
    next_cur        = cur;
    next_cur.scl_s  = {cur.scl_s[0], bus.scl};
    next_cur.sda_s  = {cur.sda_s[0], bus.sda};
    next_cur.scl_q  = cur.scl_s[1];
    next_cur.sda_q  = cur.sda_s[1];
    next_cur.pin_s0 = pin_levels;
    next_cur.pin_s1 = cur.pin_s0;
    next_cur.sl_s0  = addr_select_in_low;
    next_cur.sh_s0  = addr_select_in_high;
    next_cur.sl_s1  = cur.sl_s0;
    next_cur.sh_s1  = cur.sh_s0;
    // outputs default from select inputs once after power-up; the wait
    // lets the select synchronisers fill before their codes are trusted
    if (cur.boot != 2'h3) begin
      next_cur.boot = cur.boot + 2'h1;
    end
    if (cur.boot == 2'h2) begin
      next_cur.outs = {{4{cur.sh_s1 != pxe_pkg::SEL_GND}},
                       {4{cur.sl_s1 != pxe_pkg::SEL_GND}}};
    end
    if (start_c) begin
      // address re-read on every transmission, any target
      next_cur.addr_lo = {pxe_pkg::sel_code(MAP_HIGH, cur.sh_s1),
                          pxe_pkg::sel_code(MAP_LOW, cur.sl_s1)};
      next_cur.st      = pxe_pkg::PXE_ADDR;
      next_cur.cnt     = 4'h0;
      next_cur.sda_low = 1'b0;
    end else if (stop_c) begin
      next_cur.st      = pxe_pkg::PXE_IDLE;
      next_cur.sda_low = 1'b0;
    end else begin
      unique case (cur.st)
        pxe_pkg::PXE_IDLE, pxe_pkg::PXE_SKIP: begin
          next_cur.sda_low = 1'b0;
        end
        pxe_pkg::PXE_ADDR: begin
          if (scl_rise) begin
            next_cur.shreg = {cur.shreg[6:0], cur.sda_s[1]};
            next_cur.cnt   = cur.cnt + 4'h1;
          end
          if (scl_fall && cur.cnt == pxe_pkg::BITS_PER_BYTE) begin
            if (cur.shreg[7:1] ==
                {pxe_pkg::ADDR_PREFIX, cur.addr_lo}) begin
              next_cur.rd      = cur.shreg[0];
              next_cur.sda_low = 1'b1;
              next_cur.st      = pxe_pkg::PXE_AACK;
            end else begin
              next_cur.st = pxe_pkg::PXE_SKIP;
            end
          end
        end
        pxe_pkg::PXE_AACK, pxe_pkg::PXE_DACK: begin
          // pins sampled mid-ack, reads only
          if (scl_rise) begin
            next_cur.ack_ok = ~cur.sda_s[1];
            if (cur.rd) begin
              next_cur.shreg = cur.pin_s1;
            end
          end
          if (scl_fall) begin
            next_cur.cnt = 4'h0;
            if (cur.rd && cur.st == pxe_pkg::PXE_DACK && !cur.ack_ok) begin
              next_cur.sda_low = 1'b0;
              next_cur.st      = pxe_pkg::PXE_SKIP; // master nack ends read
            end else begin
              next_cur.st      = pxe_pkg::PXE_DATA;
              next_cur.sda_low = cur.rd & ~cur.shreg[7];
            end
          end
        end
        pxe_pkg::PXE_DATA: begin
          if (scl_rise) begin
            next_cur.cnt = cur.cnt + 4'h1;
            if (!cur.rd) begin
              next_cur.shreg = {cur.shreg[6:0], cur.sda_s[1]};
            end
          end
          if (scl_fall) begin
            if (cur.cnt == pxe_pkg::BITS_PER_BYTE) begin
              next_cur.st = pxe_pkg::PXE_DACK;
              if (cur.rd) begin
                next_cur.sda_low = 1'b0; // master acks reads
              end else begin
                next_cur.outs    = cur.shreg;
                next_cur.sda_low = 1'b1;
              end
            end else if (cur.rd) begin
              next_cur.shreg   = {cur.shreg[6:0], 1'b0};
              next_cur.sda_low = ~cur.shreg[6];
            end
          end
        end
        default: next_cur.st = pxe_pkg::PXE_IDLE;
      endcase
    end
  end

  // reset clears the serial side only, ports keep their value
  // boot keeps counting so a power-up reset cannot block the defaults
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur.scl_s   <= 2'h3;
      cur.sda_s   <= 2'h3;
      cur.scl_q   <= 1'b1;
      cur.sda_q   <= 1'b1;
      cur.st      <= pxe_pkg::PXE_IDLE;
      cur.cnt     <= 4'h0;
      cur.sda_low <= 1'b0;
      cur.rd      <= 1'b0;
      cur.ack_ok  <= 1'b0;
      cur.pin_s0  <= next_cur.pin_s0;
      cur.pin_s1  <= next_cur.pin_s1;
      cur.sl_s0   <= next_cur.sl_s0;
      cur.sh_s0   <= next_cur.sh_s0;
      cur.sl_s1   <= next_cur.sl_s1;
      cur.sh_s1   <= next_cur.sh_s1;
      cur.addr_lo <= next_cur.addr_lo;
      cur.shreg   <= next_cur.shreg;
      cur.boot    <= next_cur.boot;
      cur.outs    <= next_cur.outs;
    end else begin
      cur <= next_cur;
    end
  end

  assign push_pull_outputs = cur.outs;
  // open drain: enable low pulls, released otherwise
  assign bus.sda_dev_out   = 1'b0;
  assign bus.sda_dev_oe_b  = ~cur.sda_low;
endmodule : pxe_dev

/* hdl/pxe_host.sv */
module pxe_host (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bus
  pxe_if.host             bus,
  // user command: one transaction, n bytes
  input  wire logic       cmd_valid,
  input  wire logic [6:0] cmd_addr,
  input  wire logic       cmd_read,
  input  wire logic [3:0] cmd_len,
  input  wire logic [7:0] cmd_wdata,
  // user answer
  output logic            busy,
  output logic            byte_done,
  output logic      [7:0] rdata,
  output logic            nack
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_START = 3'b001, H_BIT = 3'b011,
    H_STOP = 3'b010, H_END = 3'b110
  } pxe_host_e;

  typedef struct packed {
    pxe_host_e  st;
    logic [1:0] sda_s;
    logic [7:0] qcnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [3:0] left;
    logic       rd;
    logic       first;
    logic [7:0] wdat;
    logic       scl_lo;
    logic       sda_lo;
    logic       done;
    logic [7:0] rdat;
    logic       nk;
  } pxe_host_s;

  pxe_host_s cur;
  pxe_host_s next_cur;
  logic      tick;

  assign tick = cur.qcnt == pxe_pkg::QUARTER_CYC;

  // bit engine, four quarters per scl period
  always_comb begin
    next_cur       = cur;
    next_cur.sda_s = {cur.sda_s[0], bus.sda};
    next_cur.done  = 1'b0;
    next_cur.qcnt  = tick ? 8'h01 : cur.qcnt + 8'h01;
    unique case (cur.st)
      H_IDLE: begin
        next_cur.qcnt = 8'h01;
        if (cmd_valid) begin
          next_cur.st    = H_START;
          next_cur.sh    = {cmd_addr, cmd_read, 1'b1};
          next_cur.left  = cmd_len;
          next_cur.rd    = cmd_read;
          next_cur.wdat  = cmd_wdata;
          next_cur.first = 1'b1;
          next_cur.nk    = 1'b0;
          next_cur.ph    = 2'h0;
        end
      end
      H_START: if (tick) begin
        next_cur.sda_lo = 1'b1;
        next_cur.st     = H_BIT;
        next_cur.bitn   = 4'h0;
      end
      H_BIT: if (tick) begin
        next_cur.ph = cur.ph + 2'h1;
        unique case (cur.ph)
          2'h0: begin
            next_cur.scl_lo = 1'b1;
          end
          2'h1: begin
            next_cur.sda_lo = ~cur.sh[8];
          end
          2'h2: begin
            next_cur.scl_lo = 1'b0;
          end
          2'h3: begin
            next_cur.sh   = {cur.sh[7:0], cur.sda_s[1]};
            next_cur.bitn = cur.bitn + 4'h1;
            if (cur.bitn == pxe_pkg::BITS_PER_BYTE) begin
              next_cur.bitn = 4'h0;
              if (!cur.first) begin
                next_cur.left = cur.left - 4'h1;
                next_cur.done = 1'b1;
                next_cur.rdat = cur.sh[7:0];
              end
              next_cur.first = 1'b0;
              if (cur.sda_s[1] && (cur.first || !cur.rd)) begin
                next_cur.nk = 1'b1;
                next_cur.st = H_STOP;
              end else if (!cur.first && cur.left == 4'h1) begin
                next_cur.st = H_STOP;
              end else if (cur.rd) begin
                // ack low unless the coming byte is the last
                next_cur.sh = {8'hff, cur.first ? cur.left == 4'h1
                                                : cur.left == 4'h2};
              end else begin
                next_cur.sh = {cur.wdat, 1'b1};
              end
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        next_cur.ph = cur.ph + 2'h1;
        unique case (cur.ph)
          2'h0: next_cur.scl_lo = 1'b1;
          2'h1: next_cur.sda_lo = 1'b1;
          2'h2: next_cur.scl_lo = 1'b0;
          2'h3: begin
            next_cur.sda_lo = 1'b0;
            next_cur.st     = H_END;
          end
        endcase
      end
      H_END: if (tick) begin
        next_cur.st = H_IDLE;
      end
      default: next_cur.st = H_IDLE;
    endcase
  end

  // reset releases both lines
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur       <= '0;
      cur.sda_s <= 2'h3;
      cur.qcnt  <= 8'h01;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy             = cur.st != H_IDLE;
  assign byte_done        = cur.done;
  assign rdata            = cur.rdat;
  assign nack             = cur.nk;
  assign bus.scl_out      = 1'b0;
  assign bus.scl_oe_b     = ~cur.scl_lo;
  assign bus.sda_host_out = 1'b0;
  assign bus.sda_host_oe_b = ~cur.sda_lo;
endmodule : pxe_host

/* tb/pxe_monitor.sv */
module pxe_monitor #(
  parameter logic [6:0] DEV_ADDR = 7'h51
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bitn;
  logic [3:0] nbyte;
  logic [7:0] sh;
  logic [7:0] adr;
  wire        rise = !scl_q && scl;
  wire        stp  = scl && scl_q && !sda_q && sda;

  // bit and byte position since the last start, cleared by reset too
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!rst_b || (scl && scl_q && sda_q && !sda)) begin
      bitn  <= 4'h0;
      nbyte <= 4'h0;
      adr   <= 8'h00;
    end else if (rise) begin
      sh   <= {sh[6:0], sda};
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
      if (bitn == 4'h8 && nbyte != 4'hf) nbyte <= nbyte + 4'h1;
      if (bitn == 4'h7 && nbyte == 4'h0) adr <= {sh[6:0], sda};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_low_only; !sda_dev_oe_b |-> !sda_dev_out; endproperty
  a_low_only: assert property (p_low_only)
    else $error("device drove sda high");
  property p_hold_high; scl && scl_q |-> $stable(sda_dev_oe_b); endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("device changed sda while scl high");
  property p_reset_idle; $rose(rst_b) |-> sda_dev_oe_b && scl; endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("bus not idle after reset");
  property p_stop_free; stp |=> sda_dev_oe_b [*8]; endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("device holds sda after stop");
  // own address ack, limited to the address this bench powers up with
  property p_addr_ack;
    rise && bitn == 4'h8 && nbyte == 4'h0 && adr[7:1] == DEV_ADDR
      |-> !sda_dev_oe_b;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");
  property p_foreign;
    (nbyte != 4'h0 || bitn == 4'h8) && adr[7:5] != pxe_pkg::ADDR_PREFIX
      |-> sda_dev_oe_b;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("device answered a foreign prefix");
  property p_write_quiet;
    rise && nbyte != 4'h0 && !adr[0] && bitn != 4'h8 |-> sda_dev_oe_b;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drove sda in write data");
  property p_write_ack;
    rise && bitn == 4'h8 && nbyte != 4'h0 && adr == {DEV_ADDR, 1'b0}
      |-> !sda_dev_oe_b;
  endproperty
  a_write_ack: assert property (p_write_ack)
    else $error("write byte not acknowledged");
endmodule : pxe_monitor

/* tb/tb_i2c_eight_output_expander.sv */
module tb_i2c_eight_output_expander;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       rst_b;
  logic       cmd_valid;
  logic       cmd_read;
  logic       busy;
  logic       byte_done;
  logic       nack;
  logic [6:0] cmd_addr;
  logic [3:0] cmd_len;
  logic [7:0] cmd_wdata;
  logic [7:0] rdata;
  logic [7:0] outs;
  logic [7:0] flip;
  logic [1:0] sel_lo;
  logic [1:0] sel_hi;
  logic [7:0] rd [0:3];
  logic [7:0] fl [0:3];
  int         mismatches;
  int         n_compared;

  pxe_if u_pxe_if ();
  // pins read back as outputs with some bits forced the other way
  pxe_dev u_pxe_dev (.clk(clk), .rst_b(rst_b), .bus(u_pxe_if.dev),
    .addr_select_in_low(sel_lo), .addr_select_in_high(sel_hi),
    .push_pull_outputs(outs), .pin_levels(outs ^ flip));
  pxe_host u_pxe_host (.clk(clk), .rst_b(rst_b), .bus(u_pxe_if.host),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
    .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .busy(busy),
    .byte_done(byte_done), .rdata(rdata), .nack(nack));
  pxe_monitor #(.DEV_ADDR(7'h51)) u_pxe_monitor (.clk(clk), .rst_b(rst_b),
    .scl(u_pxe_if.scl), .sda(u_pxe_if.sda),
    .sda_dev_out(u_pxe_if.sda_dev_out),
    .sda_dev_oe_b(u_pxe_if.sda_dev_oe_b));

  // 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task final_report;
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // one command; pins change at each byte_done to show recapture
  task xfer(input logic [6:0] a, input logic r, input logic [3:0] n,
            input logic [7:0] w);
    int k;
    int t;
    @(negedge clk);
    cmd_addr  = a;
    cmd_read  = r;
    cmd_len   = n;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    flip      = fl[0];
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    for (t = 0; t < 40000 && busy !== 1'b0; t++) begin
      if (byte_done === 1'b1) begin
        rd[k[1:0]] = rdata;
        k++;
        flip = fl[k[1:0]];
      end
      @(negedge clk);
    end
    chk("busy", 8'h00, {7'h00, busy});
  endtask : xfer

  // transfers need about 62k cycles; 80k leaves margin for a hang
  initial begin
    #(80000 * 40);
    mismatches++;
    final_report();
  end

  initial begin
    int         c;
    logic [6:0] a;
    rst_b     = 1'b0;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_addr  = 7'h00;
    cmd_len   = 4'h1;
    cmd_wdata = 8'h00;
    flip      = 8'h00;
    sel_lo    = pxe_pkg::SEL_VDD;
    sel_hi    = pxe_pkg::SEL_GND;
    fl        = '{default: 8'h00};
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    chk("powerup", 8'h0f, outs);
    xfer(7'h51, 1'b0, 4'h1, 8'ha5);
    chk("wr_nack", 8'h00, {7'h00, nack});
    chk("wr1", 8'ha5, outs);
    chk("idle", 8'h03, {6'h00, u_pxe_if.scl, u_pxe_if.sda});
    xfer(7'h51, 1'b0, 4'h3, 8'h3c);
    chk("wr3", 8'h3c, outs);
    fl[0] = 8'h0f;
    fl[1] = 8'hf0;
    fl[2] = 8'h81;
    xfer(7'h51, 1'b1, 4'h3, 8'h00);
    chk("rd0", 8'h33, rd[0]);
    chk("rd1", 8'h33, rd[1]);
    chk("rd2", 8'hcc, rd[2]);
    fl = '{default: 8'h00};
    // single-byte read: master must not ack the only byte
    xfer(7'h51, 1'b1, 4'h1, 8'h00);
    chk("rd_one", 8'h3c, rd[0]);
    // foreign prefix, then own prefix with wrong low bits
    xfer(7'h61, 1'b0, 4'h1, 8'hff);
    chk("pre_nack", 8'h01, {7'h00, nack});
    xfer(7'h50, 1'b0, 4'h1, 8'hff);
    chk("low_nack", 8'h01, {7'h00, nack});
    chk("kept", 8'h3c, outs);
    // every connection code on both select inputs, redecoded live
    for (c = 0; c < 4; c++) begin
      sel_lo = c[1:0];
      sel_hi = 2'(3 - c);
      a = {pxe_pkg::ADDR_PREFIX, pxe_pkg::SEL_MAP_HIGH[2*sel_hi +: 2],
           pxe_pkg::SEL_MAP_LOW[2*sel_lo +: 2]};
      xfer(a, 1'b0, 4'h1, {c[3:0], 4'h9});
      chk("sel", {c[3:0], 4'h9}, outs);
    end
    sel_lo = pxe_pkg::SEL_VDD;
    sel_hi = pxe_pkg::SEL_GND;
    // reset lands inside the first data byte, before it is loaded
    fork
      xfer(7'h51, 1'b0, 4'h2, 8'h5a);
      begin
        repeat (3000) @(negedge clk);
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
      end
    join
    chk("rst_keep", 8'h39, outs);
    xfer(7'h51, 1'b0, 4'h1, 8'h66);
    chk("rst_wr", 8'h66, outs);
    final_report();
  end
endmodule : tb_i2c_eight_output_expander
